// file: hw/dcss_pkg.sv
// How it works
// - counter-clockwise from terminal, serial, their AND or OR per mode 0..3
// - mode 0: setup or preset number is terminal bit pair plus one
// - mode 1: setup or preset number is serial bit pair plus one
// - mode 2: number is bitwise AND of both pairs plus one
// - mode 3: number is bitwise OR of both pairs plus one
// - setup and preset choices share the logic but keep separate modes
// - setup and preset source modes reset to logic OR, mode 3
// - direction source mode resets to terminal only, mode 0
package dcss_pkg;

  // source mode codes, as the operator selects them
  typedef enum logic [1:0]
  {
    DCSS_SRC_TERMINAL = 2'h0,
    DCSS_SRC_SERIAL   = 2'h1,
    DCSS_SRC_AND      = 2'h2,
    DCSS_SRC_OR       = 2'h3
  } dcss_src_mode_type;

  localparam int unsigned DCSS_MODE_W    = 2;
  localparam int unsigned DCSS_SEL_W     = 2;
  localparam int unsigned DCSS_NUM_W     = 3;
  localparam int unsigned DCSS_SYNC_LEN  = 3;
  localparam int unsigned DCSS_PIN_COUNT = 5;

  // values after reset
  localparam dcss_src_mode_type DCSS_DIR_MODE_RST    = DCSS_SRC_TERMINAL;
  localparam dcss_src_mode_type DCSS_SETUP_MODE_RST  = DCSS_SRC_OR;
  localparam dcss_src_mode_type DCSS_PRESET_MODE_RST = DCSS_SRC_OR;
  localparam logic [2:0]        DCSS_NUM_RST         = 3'h1;
  localparam logic [2:0]        DCSS_NUM_OFFSET      = 3'h1;
  localparam logic              DCSS_PIN_RST         = 1'h0;
  localparam logic              DCSS_CCW_RST         = 1'h0;

  // positions of the pin bits in the synchroniser bank
  localparam int unsigned DCSS_PIN_REV       = 0;
  localparam int unsigned DCSS_PIN_SETUP_LSB = 1;
  localparam int unsigned DCSS_PIN_SETUP_MSB = 2;
  localparam int unsigned DCSS_PIN_PRE_LSB   = 3;
  localparam int unsigned DCSS_PIN_PRE_MSB   = 4;

endpackage

// file: hw/dcss_combine.sv
`timescale 1ns/1ps
`default_nettype none

// combines a terminal field with a serial field under one source mode
module dcss_combine
  import dcss_pkg::*;
#(
  parameter int unsigned WIDTH = 2
)
(
  input  wire logic [1:0]       mode,
  input  wire logic [WIDTH-1:0] term_bits,
  input  wire logic [WIDTH-1:0] serial_bits,
  output logic      [WIDTH-1:0] result
);

  // pure selection; the caller registers the result
  always_comb
  begin
    unique case (dcss_src_mode_type'(mode))
      DCSS_SRC_TERMINAL: result = term_bits;
      DCSS_SRC_SERIAL:   result = serial_bits;
      DCSS_SRC_AND:      result = term_bits & serial_bits;
      DCSS_SRC_OR:       result = term_bits | serial_bits;
    endcase
  end

endmodule
`default_nettype wire

// file: hw/dcss_top.sv
`timescale 1ns/1ps
`default_nettype none

// selects direction, active setup and preset reference from terminals
// and serial control word bits
// a terminal change reaches the outputs four clocks after it is first
// sampled; a serial bit or a mode change one clock after it is taken
module dcss_top
  import dcss_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  // digital input terminals, asynchronous to core_clk
  input  wire logic       reverse_terminal_input,
  input  wire logic       setup_term_msb,
  input  wire logic       setup_term_lsb,
  input  wire logic       preset_term_msb,
  input  wire logic       preset_term_lsb,
  // control word bits, already in the core_clk domain
  input  wire logic       serial_reverse,
  input  wire logic       serial_setup_msb,
  input  wire logic       serial_setup_lsb,
  input  wire logic       serial_preset_msb,
  input  wire logic       serial_preset_lsb,
  // source mode settings, loaded on their write strobe
  input  wire logic       direction_mode_wr,
  input  wire logic [1:0] direction_mode_wdata,
  input  wire logic       setup_mode_wr,
  input  wire logic [1:0] setup_mode_wdata,
  input  wire logic       preset_mode_wr,
  input  wire logic [1:0] preset_mode_wdata,
  // results
  output logic            counter_clockwise_q,
  output logic      [2:0] setup_number_q,
  output logic      [2:0] preset_ref_number_q,
  // current settings, for read-back
  output logic      [1:0] direction_source_mode_q,
  output logic      [1:0] setup_source_mode_q,
  output logic      [1:0] preset_ref_source_mode_q
);

  ////////////////////////////////////////////////////////////////////////////
  // terminal synchronisers

  // three sampling stages per pin and the filtered level that selection reads
  logic [DCSS_PIN_COUNT-1:0] pin_raw;
  logic [DCSS_PIN_COUNT-1:0] sync1_q;
  logic [DCSS_PIN_COUNT-1:0] sync1_d;
  logic [DCSS_PIN_COUNT-1:0] sync2_q;
  logic [DCSS_PIN_COUNT-1:0] sync2_d;
  logic [DCSS_PIN_COUNT-1:0] sync3_q;
  logic [DCSS_PIN_COUNT-1:0] sync3_d;
  logic [DCSS_PIN_COUNT-1:0] pin_q;
  logic [DCSS_PIN_COUNT-1:0] pin_d;

  // gather the pins into one bank so the chain is written once
  always_comb
  begin
    pin_raw                     = '0;
    pin_raw[DCSS_PIN_REV]       = reverse_terminal_input;
    pin_raw[DCSS_PIN_SETUP_LSB] = setup_term_lsb;
    pin_raw[DCSS_PIN_SETUP_MSB] = setup_term_msb;
    pin_raw[DCSS_PIN_PRE_LSB]   = preset_term_lsb;
    pin_raw[DCSS_PIN_PRE_MSB]   = preset_term_msb;
  end

  // the first stage feeds only the second; a pin counts as changed once
  // stages two and three agree, which rejects a one-cycle glitch
  always_comb
  begin
    sync1_d = pin_raw;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    pin_d   = pin_q;
    for (int i = 0; i < DCSS_PIN_COUNT; i++)
    begin
      if (sync2_q[i] == sync3_q[i])
      begin
        pin_d[i] = sync3_q[i];
      end
    end
  end

  // all stages clear on reset, so a pin reads low until seen again
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1_q <= {DCSS_PIN_COUNT{DCSS_PIN_RST}};
      sync2_q <= {DCSS_PIN_COUNT{DCSS_PIN_RST}};
      sync3_q <= {DCSS_PIN_COUNT{DCSS_PIN_RST}};
      pin_q   <= {DCSS_PIN_COUNT{DCSS_PIN_RST}};
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      pin_q   <= pin_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source mode settings

  logic [1:0] dir_mode_d;
  logic [1:0] setup_mode_d;
  logic [1:0] preset_mode_d;

  // a strobe takes its data on the same edge; without it the setting
  // holds, whatever the data port shows
  // each selection keeps its own mode so setup and preset can differ
  always_comb
  begin
    dir_mode_d    = direction_source_mode_q;
    setup_mode_d  = setup_source_mode_q;
    preset_mode_d = preset_ref_source_mode_q;
    if (direction_mode_wr)
    begin
      dir_mode_d = direction_mode_wdata;
    end
    if (setup_mode_wr)
    begin
      setup_mode_d = setup_mode_wdata;
    end
    if (preset_mode_wr)
    begin
      preset_mode_d = preset_mode_wdata;
    end
  end

  // reset restores the factory choice of each mode
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      direction_source_mode_q  <= DCSS_DIR_MODE_RST;
      setup_source_mode_q      <= DCSS_SETUP_MODE_RST;
      preset_ref_source_mode_q <= DCSS_PRESET_MODE_RST;
    end
    else
    begin
      direction_source_mode_q  <= dir_mode_d;
      setup_source_mode_q      <= setup_mode_d;
      preset_ref_source_mode_q <= preset_mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selection

  logic [0:0] dir_sel;
  logic [1:0] setup_sel;
  logic [1:0] preset_sel;

  // combiners see flip-flop outputs and the serial input ports, so the result registers close
  // the path within one cycle at full clock rate
  // direction is a one-bit field through the same combiner
  dcss_combine #(
    .WIDTH (1)
  ) u_dir (
    .mode        (direction_source_mode_q),
    .term_bits   (pin_q[DCSS_PIN_REV]),
    .serial_bits (serial_reverse),
    .result      (dir_sel)
  );

  // setup and preset use identical logic, one instance each
  dcss_combine #(
    .WIDTH (DCSS_SEL_W)
  ) u_setup (
    .mode        (setup_source_mode_q),
    .term_bits   ({pin_q[DCSS_PIN_SETUP_MSB], pin_q[DCSS_PIN_SETUP_LSB]}),
    .serial_bits ({serial_setup_msb, serial_setup_lsb}),
    .result      (setup_sel)
  );

  dcss_combine #(
    .WIDTH (DCSS_SEL_W)
  ) u_preset (
    .mode        (preset_ref_source_mode_q),
    .term_bits   ({pin_q[DCSS_PIN_PRE_MSB], pin_q[DCSS_PIN_PRE_LSB]}),
    .serial_bits ({serial_preset_msb, serial_preset_lsb}),
    .result      (preset_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result registers

  logic       ccw_d;
  logic [2:0] setup_num_d;
  logic [2:0] preset_num_d;

  // numbers run 1..4, so the two-bit pick is widened before adding one;
  // results refresh every clock, no hold or debounce beyond the pins
  always_comb
  begin
    ccw_d        = dir_sel[0];
    setup_num_d  = {1'b0, setup_sel} + DCSS_NUM_OFFSET;
    preset_num_d = {1'b0, preset_sel} + DCSS_NUM_OFFSET;
  end

  // every result output comes straight from this register bank
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      counter_clockwise_q <= DCSS_CCW_RST;
      setup_number_q      <= DCSS_NUM_RST;
      preset_ref_number_q <= DCSS_NUM_RST;
    end
    else
    begin
      counter_clockwise_q <= ccw_d;
      setup_number_q      <= setup_num_d;
      preset_ref_number_q <= preset_num_d;
    end
  end

endmodule
`default_nettype wire

// file: verification/dcss_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches the direction and setup selection outputs at the top ports
module dcss_asserts
  import dcss_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       reverse_terminal_input,
  input wire logic       setup_term_msb,
  input wire logic       setup_term_lsb,
  input wire logic       serial_reverse,
  input wire logic       serial_setup_msb,
  input wire logic       serial_setup_lsb,
  input wire logic       setup_mode_wr,
  input wire logic [1:0] setup_mode_wdata,
  input wire logic       counter_clockwise_q,
  input wire logic [2:0] setup_number_q,
  input wire logic [1:0] direction_source_mode_q,
  input wire logic [1:0] setup_source_mode_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // source pick per mode code
  function automatic logic [1:0] sel(logic [1:0] m, logic [1:0] t, logic [1:0] s);
    return m == 2'h0 ? t : m == 2'h1 ? s : m == 2'h2 ? (t & s) : (t | s);
  endfunction
  // six quiet edges flush the four-edge terminal chain
  sequence s_steady;
    $stable({reverse_terminal_input, setup_term_msb, setup_term_lsb, serial_reverse,
      serial_setup_msb, serial_setup_lsb, direction_source_mode_q, setup_source_mode_q}) [*6];
  endsequence
  a_reset_values: assert property (disable iff (1'b0) $past(srst) |->
    setup_source_mode_q == 2'h3 && direction_source_mode_q == 2'h0 && !counter_clockwise_q
    && setup_number_q == 3'h1)
    else $error("outputs not at reset values");
  a_setup_serial: assert property (!$past(srst) && $past(setup_source_mode_q) == 2'h1 |->
    setup_number_q == $past({serial_setup_msb, serial_setup_lsb}) + 3'h1)
    else $error("serial setup number wrong");
  a_dir_serial: assert property (!$past(srst) && $past(direction_source_mode_q) == 2'h1 |->
    counter_clockwise_q == $past(serial_reverse))
    else $error("serial direction wrong");
  a_setup_select: assert property (s_steady |-> setup_number_q == 3'h1 +
    sel(setup_source_mode_q, {setup_term_msb, setup_term_lsb}, {serial_setup_msb, serial_setup_lsb}))
    else $error("setup number wrong");
  a_dir_select: assert property (s_steady |-> {1'b0, counter_clockwise_q} ==
    sel(direction_source_mode_q, {1'b0, reverse_terminal_input}, {1'b0, serial_reverse}))
    else $error("direction wrong");
  a_mode_load: assert property (!$past(srst) && $past(setup_mode_wr) |->
    setup_source_mode_q == $past(setup_mode_wdata)) else $error("mode not loaded");
  a_mode_hold: assert property (!$past(srst) && !$past(setup_mode_wr) |->
    $stable(setup_source_mode_q)) else $error("mode changed without strobe");
  a_number_range: assert property (setup_number_q inside {[3'h1:3'h4]})
    else $error("setup number out of range");
endmodule
bind dcss_top dcss_asserts dcss_asserts_inst (
  .core_clk                (core_clk),
  .srst                    (srst),
  .reverse_terminal_input  (reverse_terminal_input),
  .setup_term_msb          (setup_term_msb),
  .setup_term_lsb          (setup_term_lsb),
  .serial_reverse          (serial_reverse),
  .serial_setup_msb        (serial_setup_msb),
  .serial_setup_lsb        (serial_setup_lsb),
  .setup_mode_wr           (setup_mode_wr),
  .setup_mode_wdata        (setup_mode_wdata),
  .counter_clockwise_q     (counter_clockwise_q),
  .setup_number_q          (setup_number_q),
  .direction_source_mode_q (direction_source_mode_q),
  .setup_source_mode_q     (setup_source_mode_q)
);
`default_nettype wire

// file: verification/dcss_fieldbus_model.sv
`timescale 1ns/1ps
`default_nettype none
// control word source, launching bits just after the edge as a bus master would
module dcss_fieldbus_model
(
  input  wire logic       core_clk,
  input  wire logic [4:0] word,
  output logic      [4:0] cw_q
);
  // one stage, so the word arrives already in the core clock domain
  always_ff @(posedge core_clk)
    cw_q <= word;
endmodule
`default_nettype wire

// file: verification/dcss_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dcss_top_test;
  import dcss_pkg::*;
  logic       core_clk = 1'b0;
  logic       srst = 1'b1;
  logic [4:0] term = 5'h0; // reverse, setup msb lsb, preset msb lsb
  logic [4:0] word = 5'h0;
  logic [4:0] cw;
  logic [2:0] wr = 3'h0; // direction, setup, preset strobes
  logic [5:0] wd = 6'h0;
  logic       ccw;
  logic [2:0] sn;
  logic [2:0] pn;
  logic [1:0] dm;
  logic [1:0] sm;
  logic [1:0] pm;
  int         mismatches = 0;
  int         checks_done = 0;
  ////////////////////////////////////////////////////////////////////////
  dcss_top dcss_top_inst (.core_clk(core_clk), .srst(srst), .reverse_terminal_input(term[4]),
    .setup_term_msb(term[3]), .setup_term_lsb(term[2]), .preset_term_msb(term[1]),
    .preset_term_lsb(term[0]), .serial_reverse(cw[4]), .serial_setup_msb(cw[3]),
    .serial_setup_lsb(cw[2]), .serial_preset_msb(cw[1]), .serial_preset_lsb(cw[0]),
    .direction_mode_wr(wr[2]), .direction_mode_wdata(wd[5:4]), .setup_mode_wr(wr[1]),
    .setup_mode_wdata(wd[3:2]), .preset_mode_wr(wr[0]), .preset_mode_wdata(wd[1:0]),
    .counter_clockwise_q(ccw), .setup_number_q(sn), .preset_ref_number_q(pn),
    .direction_source_mode_q(dm), .setup_source_mode_q(sm), .preset_ref_source_mode_q(pm));
  dcss_fieldbus_model dcss_fieldbus_model_inst (.core_clk(core_clk), .word(word), .cw_q(cw));
  ////////////////////////////////////////////////////////////////////////
  // expected number for a mode, terminal pair and serial pair
  function automatic logic [2:0] num(logic [1:0] m, logic [1:0] t, logic [1:0] s);
    return {1'b0, m == 2'h0 ? t : m == 2'h1 ? s : m == 2'h2 ? (t & s) : (t | s)} + 3'h1;
  endfunction
  // compares one selection result
  task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // compares every output with its value after reset
  task automatic chk_reset;
    chk("dir_mode", 3'h0, {1'b0, dm});
    chk("setup_mode", 3'h3, {1'b0, sm});
    chk("preset_mode", 3'h3, {1'b0, pm});
    chk("ccw", 3'h0, {2'h0, ccw});
    chk("setup", 3'h1, sn);
    chk("preset", 3'h1, pn);
  endtask
  // verdict and end of run
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // watchdog, about five times the expected run
  initial
  begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    end_sim;
  end
  // main sequence: modes rotate so each code meets each selection
  initial
  begin
    void'($urandom(43));
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk_reset();
    for (int i = 0; i < 64; i++)
    begin
      @(posedge core_clk);
      wr <= 3'h7;
      wd <= {i[1:0], i[1:0] + 2'h1, i[1:0] + 2'h2};
      // first rounds pit all-ones terminals against an all-zero word
      term <= (i < 4) ? 5'h1f : 5'($urandom);
      word <= (i < 4) ? 5'h00 : 5'($urandom);
      @(posedge core_clk);
      wr <= 3'h0;
      wd <= 6'($urandom); // must be ignored while strobes are low
      repeat (7) @(posedge core_clk);
      #1;
      chk("setup_mode", {1'b0, i[1:0] + 2'h1}, {1'b0, sm});
      chk("dir_mode", {1'b0, i[1:0]}, {1'b0, dm});
      chk("preset_mode", {1'b0, i[1:0] + 2'h2}, {1'b0, pm});
      chk("ccw", num(i[1:0], {1'b0, term[4]}, {1'b0, cw[4]}) - 3'h1, {2'h0, ccw});
      chk("setup", num(i[1:0] + 2'h1, term[3:2], cw[3:2]), sn);
      chk("preset", num(i[1:0] + 2'h2, term[1:0], cw[1:0]), pn);
    end
    // a second reset must restore the modes that the loop left changed
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk_reset();
    // once the chain refills, the factory modes decide the outputs
    repeat (6) @(posedge core_clk);
    #1;
    chk("ccw", {2'h0, term[4]}, {2'h0, ccw});
    chk("setup", num(2'h3, term[3:2], cw[3:2]), sn);
    chk("preset", num(2'h3, term[1:0], cw[1:0]), pn);
    end_sim;
  end
endmodule
`default_nettype wire
